// *** hdl/fcs_defines.svh ***
// Constants for the fast context shadow stack.
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
`define FCS_PC_W       21
`define FCS_TP_W       22
`define FCS_STK_D      8
`define FCS_STK_AW     3
`define FCS_PC_RST     21'h000000
`define FCS_TP_RST     22'h000000
`define FCS_BYTE_RST   8'h00
`define FCS_BSR_RST    4'h0
`define FCS_STAT_RST   5'h00
`define FCS_SP_RST     3'h0
`define FCS_SP_ONE     3'h1
`define FCS_PC_STEP    21'h000002
`define FCS_VEC_HI     21'h000008
`define FCS_VEC_LO     21'h000018
`endif

// *** hdl/fcs_pkg.sv ***
// Types for the fast context shadow stack.
package fcs_pkg;
  typedef enum logic [3:0] {
    FCS_OP_NOP, FCS_OP_CALL, FCS_OP_RETURN, FCS_OP_RET_INT, FCS_OP_RET_LIT,
    FCS_OP_ADD_W_PC, FCS_OP_TBLRD, FCS_OP_TBLWT, FCS_OP_WRITE_REGS
  } fcs_op_t;
endpackage

// *** hdl/fcs_shadow_core.sv ***
// Fast context shadow stack with program-memory look-up support.
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_shadow_core (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire fcs_pkg::fcs_op_t       op,
  input  wire logic                   op_valid,
  input  wire logic                   op_fast,
  input  wire logic [`FCS_PC_W-1:0]   op_target,
  input  wire logic [7:0]             op_literal,
  input  wire logic                   irq_take,
  input  wire logic                   irq_high,
  input  wire logic [4:0]             wr_status,
  input  wire logic [7:0]             wr_working,
  input  wire logic [3:0]             wr_bank,
  input  wire logic                   wr_tp_en,
  input  wire logic [`FCS_TP_W-1:0]   wr_tp,
  input  wire logic                   wr_latch_en,
  input  wire logic [7:0]             wr_latch,
  input  wire logic [15:0]            pm_rdata,
  output logic [`FCS_PC_W-1:0]        pc,
  output logic [4:0]                  status_register,
  output logic [7:0]                  working_register,
  output logic [3:0]                  bank_select_register,
  output logic [`FCS_TP_W-1:0]        table_pointer,
  output logic [7:0]                  table_latch,
  output logic [`FCS_TP_W-2:0]        pm_word_addr,
  output logic                        pm_wr_en,
  output logic [15:0]                 pm_wdata,
  output logic [1:0]                  pm_byte_en
);
  import fcs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [`FCS_PC_W-1:0]                 pc;
    logic [4:0]                           st;
    logic [7:0]                           wk;
    logic [3:0]                           bk;
    logic [4:0]                           sh_st;
    logic [7:0]                           sh_wk;
    logic [3:0]                           sh_bk;
    logic [`FCS_TP_W-1:0]                 tp;
    logic [7:0]                           tl;
    logic [`FCS_STK_AW-1:0]               sp;
    logic [`FCS_STK_D*`FCS_PC_W-1:0]      stk;
    logic [`FCS_TP_W-2:0]                 pa;
    logic                                 pw;
    logic [15:0]                          pd;
    logic [1:0]                           pb;
  } fcs_state_t;

  fcs_state_t state_r;
  fcs_state_t state_nxt;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [`FCS_PC_W-1:0] top;
    logic [`FCS_STK_AW-1:0] spm;
    state_nxt = state_r;
    spm = state_r.sp - `FCS_SP_ONE;
    top = state_r.stk[spm*`FCS_PC_W +: `FCS_PC_W];
    state_nxt.pw = 1'b0;
    state_nxt.pb = 2'b00;
    if (irq_take) begin
      // Any source of either priority saves context and overwrites older copies.
      state_nxt.sh_st = state_r.st;
      state_nxt.sh_wk = state_r.wk;
      state_nxt.sh_bk = state_r.bk;
      state_nxt.stk[state_r.sp*`FCS_PC_W +: `FCS_PC_W] = state_r.pc;
      state_nxt.sp = state_r.sp + `FCS_SP_ONE;
      state_nxt.pc = irq_high ? `FCS_VEC_HI : `FCS_VEC_LO;
    end else if (op_valid) begin
      state_nxt.pc = state_r.pc + `FCS_PC_STEP;
      unique case (op)
        FCS_OP_NOP: begin
        end
        FCS_OP_WRITE_REGS: begin
          state_nxt.st = wr_status;
          state_nxt.wk = wr_working;
          state_nxt.bk = wr_bank;
        end
        FCS_OP_CALL: begin
          state_nxt.stk[state_r.sp*`FCS_PC_W +: `FCS_PC_W] = state_r.pc + `FCS_PC_STEP;
          state_nxt.sp = state_r.sp + `FCS_SP_ONE;
          state_nxt.pc = op_target;
          if (op_fast) begin
            state_nxt.sh_st = state_r.st;
            state_nxt.sh_wk = state_r.wk;
            state_nxt.sh_bk = state_r.bk;
          end
        end
        FCS_OP_RETURN, FCS_OP_RET_INT: begin
          state_nxt.pc = top;
          state_nxt.sp = spm;
          if (op_fast) begin
            state_nxt.st = state_r.sh_st;
            state_nxt.wk = state_r.sh_wk;
            state_nxt.bk = state_r.sh_bk;
          end
        end
        FCS_OP_RET_LIT: begin
          state_nxt.pc = top;
          state_nxt.sp = spm;
          state_nxt.wk = op_literal;
        end
        FCS_OP_ADD_W_PC: begin
          // Offset is a byte count; software keeps it even.
          state_nxt.pc = state_r.pc + `FCS_PC_STEP + {13'h0000, state_r.wk};
        end
        FCS_OP_TBLRD: begin
          // Low address bit selects the byte within the word.
          state_nxt.tl = state_r.tp[0] ? pm_rdata[15:8] : pm_rdata[7:0];
        end
        FCS_OP_TBLWT: begin
          state_nxt.pw = 1'b1;
          state_nxt.pd = {state_r.tl, state_r.tl};
          state_nxt.pb = state_r.tp[0] ? 2'b10 : 2'b01;
        end
        default: begin
        end
      endcase
    end
    if (wr_tp_en) begin
      state_nxt.tp = wr_tp;
    end
    if (wr_latch_en) begin
      state_nxt.tl = wr_latch;
    end
    state_nxt.pa = state_nxt.tp[`FCS_TP_W-1:1];
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pc                   = state_r.pc;
  assign status_register      = state_r.st;
  assign working_register     = state_r.wk;
  assign bank_select_register = state_r.bk;
  assign table_pointer        = state_r.tp;
  assign table_latch          = state_r.tl;
  assign pm_word_addr         = state_r.pa;
  assign pm_wr_en             = state_r.pw;
  assign pm_wdata             = state_r.pd;
  assign pm_byte_en           = state_r.pb;
endmodule // fcs_shadow_core

// *** sim/fcs_pm_model.sv ***
// Program memory model behind the table access port.
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_pm_model (
  input  wire logic                 sys_clk,
  input  wire logic [`FCS_TP_W-2:0] pm_word_addr,
  input  wire logic                 pm_wr_en,
  input  wire logic [15:0]          pm_wdata,
  input  wire logic [1:0]           pm_byte_en,
  output logic [15:0]               pm_rdata
);
  logic [15:0] mem [16];
  initial for (int i = 0; i < 16; i++) mem[i] = {4'ha, i[3:0], 4'h5, i[3:0]};
  assign pm_rdata = mem[pm_word_addr[3:0]];
  always @(posedge sys_clk) begin
    if (pm_wr_en && pm_byte_en[0]) mem[pm_word_addr[3:0]][7:0] <= pm_wdata[7:0];
    if (pm_wr_en && pm_byte_en[1]) mem[pm_word_addr[3:0]][15:8] <= pm_wdata[15:8];
  end
endmodule // fcs_pm_model

// *** sim/fcs_shadow_checker.sv ***
// Concurrent checks on the shadow core ports.
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_shadow_checker (
  input wire logic sys_clk, rst, op_valid, op_fast, irq_take, irq_high, wr_latch_en, pm_wr_en,
  input wire fcs_pkg::fcs_op_t     op,
  input wire logic [7:0]           op_literal, working_register, table_latch,
  input wire logic [15:0]          pm_rdata,
  input wire logic [`FCS_PC_W-1:0] pc,
  input wire logic [4:0]           status_register,
  input wire logic [3:0]           bank_select_register,
  input wire logic [`FCS_TP_W-1:0] table_pointer,
  input wire logic [`FCS_TP_W-2:0] pm_word_addr,
  input wire logic [1:0]           pm_byte_en
);
  import fcs_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire        tk   = op_valid && !irq_take;
  wire [16:0] regs = {status_register, working_register, bank_select_register};
  logic [16:0] sh_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) sh_r <= 17'h0;
    else if (irq_take || (op_valid && op_fast && op == FCS_OP_CALL)) sh_r <= regs;
  end
  vec_pick_a: assert property (
    irq_take |=> pc == ($past(irq_high) ? `FCS_VEC_HI : `FCS_VEC_LO)) else $error("vector");
  ctx_restore_a: assert property (
    tk && op_fast && (op == FCS_OP_RET_INT || op == FCS_OP_RETURN)
    |=> regs == sh_r) else $error("restore");
  plain_keep_a: assert property (
    tk && !op_fast && (op == FCS_OP_CALL || op == FCS_OP_RETURN)
    |=> $stable(regs)) else $error("plain");
  lit_load_a: assert property (
    tk && op == FCS_OP_RET_LIT |=> working_register == $past(op_literal)) else $error("literal");
  jump_add_a: assert property (
    tk && op == FCS_OP_ADD_W_PC
    |=> pc == $past(pc) + `FCS_PC_STEP + $past(working_register)) else $error("jump");
  word_addr_a: assert property (
    pm_word_addr == table_pointer[`FCS_TP_W-1:1]) else $error("word");
  byte_read_a: assert property (
    tk && op == FCS_OP_TBLRD && !wr_latch_en |=> table_latch ==
    ($past(table_pointer[0]) ? $past(pm_rdata[15:8]) : $past(pm_rdata[7:0]))) else $error("rd");
  byte_write_a: assert property (
    tk && op == FCS_OP_TBLWT |=> pm_wr_en &&
    pm_byte_en == ($past(table_pointer[0]) ? 2'h2 : 2'h1)) else $error("wr");
endmodule // fcs_shadow_checker
bind fcs_shadow_core fcs_shadow_checker chk (.*);

// *** sim/tb.sv ***
// Self-checking bench for the shadow core.
`timescale 1ns/1ps
`include "fcs_defines.svh"
module tb;
  import fcs_pkg::*;
  logic sys_clk, rst, op_valid, op_fast, irq_take, irq_high, wr_tp_en, wr_latch_en, pm_wr_en;
  fcs_op_t              op;
  logic [`FCS_PC_W-1:0] op_target, pc, p;
  logic [7:0]           op_literal, wr_working, wr_latch, working_register, table_latch;
  logic [4:0]           wr_status, status_register;
  logic [3:0]           wr_bank, bank_select_register;
  logic [`FCS_TP_W-1:0] wr_tp, table_pointer;
  logic [`FCS_TP_W-2:0] pm_word_addr;
  logic [15:0]          pm_rdata, pm_wdata;
  logic [1:0]           pm_byte_en;
  int                   miscompares, checks;
  wire [16:0]           regs = {status_register, working_register, bank_select_register};
  fcs_shadow_core uut (.*);
  fcs_pm_model pm (.*);
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  task test_done;
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task t(input fcs_op_t o, input logic f);
    @(posedge sys_clk);
    {op, op_fast, op_valid} <= {o, f, 1'h1};
    @(posedge sys_clk);
    op_valid <= 1'h0;
    #1;
  endtask
  task irq(input logic h);
    @(posedge sys_clk);
    {irq_take, irq_high} <= {1'h1, h};
    @(posedge sys_clk);
    irq_take <= 1'h0;
    #1;
  endtask
  task wr(input logic [16:0] v);
    {wr_status, wr_working, wr_bank} <= v;
    t(FCS_OP_WRITE_REGS, 1'h0);
  endtask
  task s_call;
    wr(17'h0a5a5);
    t(FCS_OP_CALL, 1'h1);
    cmp(pc, 32'h100);
    wr(17'h13c33);
    t(FCS_OP_CALL, 1'h0);
    t(FCS_OP_RETURN, 1'h0);
    cmp(regs, 32'h13c33);
    t(FCS_OP_RETURN, 1'h1);
    cmp(regs, 32'h0a5a5);
  endtask
  task s_irq;
    wr(17'h01111);
    irq(1'h0);
    cmp(pc, 32'h18);
    wr(17'h02222);
    irq(1'h1);
    cmp(pc, 32'h8);
    wr(17'h03333);
    t(FCS_OP_RET_INT, 1'h1);
    cmp(regs, 32'h02222);
  endtask
  task s_tbl;
    {wr_tp, wr_tp_en} <= {22'h3, 1'h1};
    t(FCS_OP_NOP, 1'h0);
    wr_tp_en <= 1'h0;
    t(FCS_OP_TBLRD, 1'h0);
    cmp(table_latch, 32'ha1);
    {wr_latch, wr_latch_en} <= {8'h3c, 1'h1};
    t(FCS_OP_NOP, 1'h0);
    wr_latch_en <= 1'h0;
    t(FCS_OP_TBLWT, 1'h0);
    t(FCS_OP_TBLRD, 1'h0);
    cmp(table_latch, 32'h3c);
  endtask
  task s_jump;
    wr(17'h00040);
    p = pc;
    t(FCS_OP_ADD_W_PC, 1'h0);
    cmp(pc, p + 21'h6);
    t(FCS_OP_RET_LIT, 1'h0);
    cmp(working_register, 32'h77);
  endtask
  initial begin
    {rst, op_valid, op_fast, irq_take, irq_high, wr_tp_en, wr_latch_en} = 7'h40;
    {op, op_target, op_literal, wr_tp, wr_latch} = {FCS_OP_NOP, 21'h100, 8'h77, 22'h0, 8'h0};
    {wr_status, wr_working, wr_bank} = 17'h0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    s_call;
    s_irq;
    s_tbl;
    s_jump;
    test_done;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end
endmodule // tb
